// file: hdl/nscr_regs.sv
// node configuration register bank of the on-chip packet switch
// assumes requests arrive one per cycle at most on the switch clock;
// boot select pins come from outside and are synchronised here
//
// What this block does
// - switch config bit 0 picks one-byte headers when set, two-byte when clear
// - switch config bit 31 set refuses writes to switch control registers
// - switch config bit 8 set blocks writes to the pll control register
// - an accepted pll settings write with bit 31 clear requests a tile reset
// - pll write bit 31 set applies settings with no tile reset
// - pll write bit 30 set skips waiting for pll relock
// - pll bit 29 bypasses the pll with the input clock
// - pll bit 28 forces boot through the jtag port
// - pll output divide held in bits 25 to 23
// - pll feedback multiplier held in bits 20 to 8
// - oscillator input divide held in bits 6 to 0
// - switch clock ratio is a 16-bit field resetting to zero
// - reference clock ratio is a 16-bit field resetting to three
// - node identifier is 16 bits, upper half reserved, reset zero
// - identity register shows boot pins, switch revision and version
// - resource register shows link, switch core and device core counts
// - route packets by most significant destination and node id mismatch
// - low direction register holds dimensions 0 to 7, four bits each
// - high direction register holds dimensions 8 to 15, four bits each
// - user code register shows otp user code and metal id code
// - registers are reached by numbered configuration reads and writes
`timescale 1ns/1ps
`default_nettype none

module nscr_regs #(
  parameter logic [7:0] SWITCH_REVISION = 8'h00, // arbitrary value
  parameter logic [7:0] SWITCH_VERSION = 8'h00, // arbitrary value
  parameter logic [7:0] NUM_LINKS = 8'h08,
  parameter logic [7:0] NUM_SWITCH_CORES = 8'h02,
  parameter logic [7:0] NUM_DEVICE_CORES = 8'h02
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire nscr_pkg::nscr_cfg_req_t cfgReq,
  output var nscr_pkg::nscr_cfg_rsp_t cfgRsp,
  input wire logic [7:0] bootSelectPins,
  input wire logic [31:0] jtagIdentity,
  input wire logic [13:0] otpUserCode,
  input wire logic [17:0] metalIdCode,
  input wire logic routeReqValid,
  input wire logic [15:0] routeDest,
  output var nscr_pkg::nscr_route_t routeOut,
  output logic hdrOneByte,
  output logic [15:0] nodeId,
  output logic [15:0] switchClkDiv,
  output logic [15:0] refClkDiv,
  output var nscr_pkg::nscr_pll_ctl_t pllCtl
);
  import nscr_pkg::*;

  // finds the highest differing bit; top bit says whether any differs
  function automatic logic [4:0] msbMismatch(input logic [15:0] diff);
    logic [4:0] res;
    res = 5'h00;
    for (int i = 0; i < 16; i++) begin
      if (diff[i]) begin
        res = {1'b1, 4'(i)};
      end
    end
    return res;
  endfunction : msbMismatch

  // picks one four-bit direction out of the two direction words
  function automatic logic [3:0] pickDir(input logic [63:0] dirs,
                                         input logic [3:0] dim);
    logic [3:0] res;
    res = 4'h0;
    for (int k = 0; k < 16; k++) begin
      if (dim == 4'(k)) begin
        res = dirs[4*k +: 4];
      end
    end
    return res;
  endfunction : pickDir

  logic [31:0] cfg_q;
  logic [15:0] node_q;
  logic [31:0] pll_q;
  logic [15:0] swDiv_q;
  logic [15:0] refDiv_q;
  logic [31:0] dirLo_q;
  logic [31:0] dirHi_q;
  logic [7:0] bootMeta_q;
  logic [7:0] bootSync_q;
  logic [7:0] bootCap_q;
  logic [1:0] settle_q;
  logic pllUpdate_q;
  logic tileReset_q;
  logic waitLock_q;
  logic rspValid_q;
  logic rspRefused_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic rdHit;
  logic wrReq;
  logic ctlLocked;
  logic wrCfg;
  logic wrNode;
  logic wrPll;
  logic wrSwDiv;
  logic wrRefDiv;
  logic wrDirLo;
  logic wrDirHi;
  logic wrTaken;
  logic [4:0] mism;
  logic routeValid_q;
  logic routeLocal_q;
  logic [3:0] routeDir_q;

  // write decode; the switch config word itself stays writable so
  // software can lift the control lock again
  assign wrReq = cfgReq.valid && cfgReq.write;
  assign ctlLocked = cfg_q[CFG_CTL_LOCK_BIT];
  assign wrCfg = wrReq && cfgReq.regNum == REG_SWITCH_SECURITY_HEADER_CFG;
  assign wrNode = wrReq && cfgReq.regNum == REG_NODE_IDENTIFIER && !ctlLocked;
  assign wrPll = wrReq && cfgReq.regNum == REG_PLL_SETTINGS && !ctlLocked
                 && !cfg_q[CFG_PLL_LOCK_BIT];
  assign wrSwDiv = wrReq && cfgReq.regNum == REG_SWITCH_CLOCK_RATIO && !ctlLocked;
  assign wrRefDiv = wrReq && cfgReq.regNum == REG_REFERENCE_CLOCK_RATIO && !ctlLocked;
  assign wrDirLo = wrReq && cfgReq.regNum == REG_ROUTE_DIRECTIONS_LOW && !ctlLocked;
  assign wrDirHi = wrReq && cfgReq.regNum == REG_ROUTE_DIRECTIONS_HIGH && !ctlLocked;
  assign wrTaken = wrCfg || wrNode || wrPll || wrSwDiv || wrRefDiv
                   || wrDirLo || wrDirHi;

  // switch security and header word
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cfg_q <= RST_CFG;
    end else if (wrCfg) begin
      cfg_q <= cfgReq.wdata & MASK_CFG;
    end
  end

  // node identifier
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      node_q <= RST_NODE;
    end else if (wrNode) begin
      node_q <= cfgReq.wdata[15:0];
    end
  end

  // pll settings word, reserved bits dropped
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pll_q <= RST_PLL;
    end else if (wrPll) begin
      pll_q <= cfgReq.wdata & MASK_PLL;
    end
  end

  // one-cycle effects of an accepted pll write
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pllUpdate_q <= 1'b0;
      tileReset_q <= 1'b0;
      waitLock_q <= 1'b0;
    end else begin
      pllUpdate_q <= wrPll;
      tileReset_q <= wrPll && !cfgReq.wdata[PLL_NO_RESET_BIT];
      waitLock_q <= wrPll && !cfgReq.wdata[PLL_NO_WAIT_BIT];
    end
  end

  // clock ratio fields
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      swDiv_q <= RST_SWITCH_DIV;
      refDiv_q <= RST_REF_DIV;
    end else begin
      if (wrSwDiv) begin
        swDiv_q <= cfgReq.wdata[15:0];
      end
      if (wrRefDiv) begin
        refDiv_q <= cfgReq.wdata[15:0];
      end
    end
  end

  // routing direction words
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      dirLo_q <= RST_DIRS;
      dirHi_q <= RST_DIRS;
    end else begin
      if (wrDirLo) begin
        dirLo_q <= cfgReq.wdata;
      end
      if (wrDirHi) begin
        dirHi_q <= cfgReq.wdata;
      end
    end
  end

  // boot pin synchroniser
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      bootMeta_q <= 8'h00;
      bootSync_q <= 8'h00;
    end else begin
      bootMeta_q <= bootSelectPins;
      bootSync_q <= bootMeta_q;
    end
  end

  // catch the boot pins once, after the synchroniser has filled
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      settle_q <= 2'd0;
      bootCap_q <= 8'h00;
    end else if (settle_q != 2'd3) begin
      settle_q <= settle_q + 2'd1;
      if (settle_q == BOOT_SETTLE) begin
        bootCap_q <= bootSync_q;
      end
    end
  end

  // read mux; unmapped numbers read zero
  always_comb begin
    rdata_d = 32'h0000_0000;
    rdHit = 1'b1;
    case (cfgReq.regNum)
      REG_DEVICE_IDENTITY_INFO: begin
        rdata_d = {8'h00, bootCap_q, SWITCH_REVISION, SWITCH_VERSION};
      end
      REG_SWITCH_RESOURCE_COUNTS: begin
        rdata_d = {8'h00, NUM_LINKS, NUM_SWITCH_CORES, NUM_DEVICE_CORES};
      end
      REG_SWITCH_SECURITY_HEADER_CFG: rdata_d = cfg_q;
      REG_NODE_IDENTIFIER: rdata_d = {16'h0000, node_q};
      REG_PLL_SETTINGS: rdata_d = pll_q;
      REG_SWITCH_CLOCK_RATIO: rdata_d = {16'h0000, swDiv_q};
      REG_REFERENCE_CLOCK_RATIO: rdata_d = {16'h0000, refDiv_q};
      REG_JTAG_IDENTITY_MIRROR: rdata_d = jtagIdentity;
      REG_USER_CODE_MIRROR: rdata_d = {otpUserCode, metalIdCode};
      REG_ROUTE_DIRECTIONS_LOW: rdata_d = dirLo_q;
      REG_ROUTE_DIRECTIONS_HIGH: rdata_d = dirHi_q;
      default: begin
        rdHit = 1'b0;
      end
    endcase
  end

  // answer one cycle after each request
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rspValid_q <= 1'b0;
      rspRefused_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      rspValid_q <= cfgReq.valid;
      rspRefused_q <= cfgReq.valid && (cfgReq.write ? !wrTaken : !rdHit);
      if (cfgReq.valid && !cfgReq.write) begin
        rdata_q <= rdata_d;
      end
    end
  end

  // routing decision, registered
  assign mism = msbMismatch(routeDest ^ node_q);

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      routeValid_q <= 1'b0;
      routeLocal_q <= 1'b0;
      routeDir_q <= 4'h0;
    end else begin
      routeValid_q <= routeReqValid;
      if (routeReqValid) begin
        routeLocal_q <= !mism[4];
        routeDir_q <= mism[4] ? pickDir({dirHi_q, dirLo_q}, mism[3:0]) : 4'h0;
      end
    end
  end

  // outputs from the register state
  assign cfgRsp = '{valid: rspValid_q, refused: rspRefused_q, rdata: rdata_q};
  assign routeOut = '{valid: routeValid_q, isLocal: routeLocal_q, dir: routeDir_q};
  assign hdrOneByte = cfg_q[CFG_HDR_BIT];
  assign nodeId = node_q;
  assign switchClkDiv = swDiv_q;
  assign refClkDiv = refDiv_q;
  // one driver for the whole pll control word
  assign pllCtl = '{update: pllUpdate_q,
                    tileReset: tileReset_q,
                    waitLock: waitLock_q,
                    bypass: pll_q[PLL_BYPASS_BIT],
                    jtagBoot: pll_q[PLL_JTAG_BOOT_BIT],
                    outDiv: pll_q[PLL_OD_LSB +: 3],
                    fbMul: pll_q[PLL_F_LSB +: 13],
                    inDiv: pll_q[PLL_R_LSB +: 7]};

  // checks on the register bank
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  property p_rsp_timing;
    cfgReq.valid |=> cfgRsp.valid ##1 (cfgRsp.valid == $past(cfgReq.valid));
  endproperty
  a_rsp_timing: assert property (p_rsp_timing)
    else $error("answer not one cycle after request");

  property p_ctl_lock;
    (ctlLocked && wrReq && cfgReq.regNum == REG_NODE_IDENTIFIER)
      |=> $stable(nodeId) && cfgRsp.refused;
  endproperty
  a_ctl_lock: assert property (p_ctl_lock)
    else $error("locked node id write took effect");

  property p_pll_lock;
    (cfg_q[CFG_PLL_LOCK_BIT] && wrReq && cfgReq.regNum == REG_PLL_SETTINGS)
      |=> !pllCtl.update && $stable(pll_q);
  endproperty
  a_pll_lock: assert property (p_pll_lock)
    else $error("locked pll write took effect");

  property p_tile_reset;
    (wrPll && !cfgReq.wdata[PLL_NO_RESET_BIT]) |=> pllCtl.tileReset
      ##1 (pllCtl.tileReset == $past(wrPll && !cfgReq.wdata[PLL_NO_RESET_BIT]));
  endproperty
  a_tile_reset: assert property (p_tile_reset)
    else $error("pll write gave no single tile reset pulse");

  property p_no_reset;
    (wrPll && cfgReq.wdata[PLL_NO_RESET_BIT]) |=> pllCtl.update && !pllCtl.tileReset;
  endproperty
  a_no_reset: assert property (p_no_reset)
    else $error("suppressed reset still raised");

  property p_wait_lock;
    pllCtl.waitLock |-> $past(wrPll) && !$past(cfgReq.wdata[PLL_NO_WAIT_BIT]);
  endproperty
  a_wait_lock: assert property (p_wait_lock)
    else $error("relock wait without cause");

  property p_ro_write;
    (wrReq && cfgReq.regNum == REG_DEVICE_IDENTITY_INFO) |=> cfgRsp.refused;
  endproperty
  a_ro_write: assert property (p_ro_write)
    else $error("read-only write not refused");

  property p_route_local;
    (routeReqValid && routeDest == nodeId) |=> routeOut.valid && routeOut.isLocal;
  endproperty
  a_route_local: assert property (p_route_local)
    else $error("own address not routed locally");

  property p_header;
    wrCfg |=> hdrOneByte == $past(cfgReq.wdata[CFG_HDR_BIT]);
  endproperty
  a_header: assert property (p_header)
    else $error("header mode not taken from write");

  property p_fields;
    wrPll |=> pllCtl.fbMul == $past(cfgReq.wdata[20:8])
              && pllCtl.outDiv == $past(cfgReq.wdata[25:23]);
  endproperty
  a_fields: assert property (p_fields)
    else $error("pll fields misplaced");

  // main scenarios
  c_pll_no_reset: cover property (wrPll && cfgReq.wdata[PLL_NO_RESET_BIT]);
  c_route_far: cover property (routeOut.valid && !routeOut.isLocal);
  c_locked_write: cover property (ctlLocked && wrReq && !wrTaken);
  c_pll_reset: cover property (pllCtl.tileReset);

endmodule : nscr_regs

`default_nettype wire

// file: hdl/nscr_pkg.sv
// package for the node configuration register bank: numbers, masks, resets, carriers
// assumes a single switch clock domain and 32-bit configuration words
package nscr_pkg;

  // register numbers of the node configuration space
  localparam logic [7:0] REG_DEVICE_IDENTITY_INFO = 8'h00;
  localparam logic [7:0] REG_SWITCH_RESOURCE_COUNTS = 8'h01;
  localparam logic [7:0] REG_SWITCH_SECURITY_HEADER_CFG = 8'h04;
  localparam logic [7:0] REG_NODE_IDENTIFIER = 8'h05;
  localparam logic [7:0] REG_PLL_SETTINGS = 8'h06;
  localparam logic [7:0] REG_SWITCH_CLOCK_RATIO = 8'h07;
  localparam logic [7:0] REG_REFERENCE_CLOCK_RATIO = 8'h08;
  localparam logic [7:0] REG_JTAG_IDENTITY_MIRROR = 8'h09;
  localparam logic [7:0] REG_USER_CODE_MIRROR = 8'h0A;
  localparam logic [7:0] REG_ROUTE_DIRECTIONS_LOW = 8'h0C;
  localparam logic [7:0] REG_ROUTE_DIRECTIONS_HIGH = 8'h0D;

  // switch security and header bits
  localparam int CFG_CTL_LOCK_BIT = 31;
  localparam int CFG_PLL_LOCK_BIT = 8;
  localparam int CFG_HDR_BIT = 0;

  // pll settings fields
  localparam int PLL_NO_RESET_BIT = 31;
  localparam int PLL_NO_WAIT_BIT = 30;
  localparam int PLL_BYPASS_BIT = 29;
  localparam int PLL_JTAG_BOOT_BIT = 28;
  localparam int PLL_OD_LSB = 23;
  localparam int PLL_F_LSB = 8;
  localparam int PLL_R_LSB = 0;

  // identity and user code field positions
  localparam int ID_BOOT_LSB = 16;
  localparam int ID_REV_LSB = 8;
  localparam int USER_OTP_LSB = 18;

  // writable bit masks, reserved bits read zero
  localparam logic [31:0] MASK_CFG = 32'h8000_0101;
  localparam logic [31:0] MASK_NODE = 32'h0000_FFFF;
  localparam logic [31:0] MASK_PLL = 32'hF39F_FF7F;
  localparam logic [31:0] MASK_DIV = 32'h0000_FFFF;

  // reset values
  localparam logic [31:0] RST_CFG = 32'h0000_0000;
  localparam logic [15:0] RST_NODE = 16'h0000;
  localparam logic [31:0] RST_PLL = 32'h0000_0000;
  localparam logic [15:0] RST_SWITCH_DIV = 16'h0000;
  localparam logic [15:0] RST_REF_DIV = 16'h0003;
  localparam logic [31:0] RST_DIRS = 32'h0000_0000;

  // edges after reset release before the boot pins are captured
  localparam logic [1:0] BOOT_SETTLE = 2'd2;

  // configuration request from the interconnect
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] regNum;
    logic [31:0] wdata;
  } nscr_cfg_req_t;

  // answer to a configuration request
  typedef struct packed {
    logic valid;
    logic refused;
    logic [31:0] rdata;
  } nscr_cfg_rsp_t;

  // pll controls as seen by the clock generator
  typedef struct packed {
    logic update;
    logic tileReset;
    logic waitLock;
    logic bypass;
    logic jtagBoot;
    logic [2:0] outDiv;
    logic [12:0] fbMul;
    logic [6:0] inDiv;
  } nscr_pll_ctl_t;

  // routing decision for one packet
  typedef struct packed {
    logic valid;
    logic isLocal;
    logic [3:0] dir;
  } nscr_route_t;

endpackage : nscr_pkg

// file: dv/nscr_cfg_requester.sv
// requester model: issues numbered configuration reads and writes
// assumes the switch clock; drives at the falling edge, one request a cycle
`timescale 1ns/1ps
`default_nettype none
module nscr_cfg_requester (
  input wire logic core_clk,
  output var nscr_pkg::nscr_cfg_req_t cfgReq
);
  import nscr_pkg::*;
  // bus starts idle
  initial begin
    cfgReq = '0;
  end
  // one request per call; back to back when called again
  task automatic issue(input logic w, input logic [7:0] r, input logic [31:0] d);
    @(negedge core_clk);
    cfgReq.valid <= 1'b1;
    cfgReq.write <= w;
    cfgReq.regNum <= r;
    cfgReq.wdata <= d;
  endtask : issue
  // release: stale fields inverted so they never look like a live request
  task automatic idle();
    @(negedge core_clk);
    cfgReq.valid <= 1'b0;
    cfgReq.write <= ~cfgReq.write;
    cfgReq.regNum <= ~cfgReq.regNum;
    cfgReq.wdata <= ~cfgReq.wdata;
  endtask : idle
endmodule : nscr_cfg_requester
`default_nettype wire

// file: dv/node_switch_config_regs_test.sv
// self-checking bench for the node configuration register bank
// assumes the requester model in the same folder and default parameters
`timescale 1ns/1ps
`default_nettype none
module node_switch_config_regs_test;
  import nscr_pkg::*;
  typedef struct packed {
    logic isRd;
    logic refd;
    logic [2:0] pls;
    logic [31:0] rd;
    logic [31:0] cfg;
    logic [31:0] node;
    logic [31:0] pll;
    logic [31:0] d7;
    logic [31:0] d8;
  } nscr_exp_t;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  nscr_cfg_req_t cfgReq;
  nscr_cfg_rsp_t cfgRsp;
  nscr_route_t routeOut;
  nscr_pll_ctl_t pllCtl;
  logic [7:0] bootPins;
  logic [31:0] jtagId;
  logic [13:0] otp;
  logic [17:0] metal;
  logic routeReqValid = 1'b0;
  logic [15:0] routeDest = 16'h0000;
  logic hdrOneByte;
  logic [15:0] nodeId;
  logic [15:0] switchClkDiv;
  logic [15:0] refClkDiv;
  logic [31:0] seed = 32'h0000_2AFB;
  logic [31:0] t;
  logic [31:0] mdl [16];
  nscr_exp_t expQ [$];
  nscr_exp_t we;
  logic [4:0] routeQ [$];
  int badCount = 0;
  int nTests = 0;
  int cycles = 0;

  // switch clock, 100 MHz
  always #5 core_clk = ~core_clk;

  nscr_regs DUT (.core_clk(core_clk), .resetn(resetn), .cfgReq(cfgReq), .cfgRsp(cfgRsp),
    .bootSelectPins(bootPins), .jtagIdentity(jtagId), .otpUserCode(otp),
    .metalIdCode(metal), .routeReqValid(routeReqValid), .routeDest(routeDest),
    .routeOut(routeOut), .hdrOneByte(hdrOneByte), .nodeId(nodeId),
    .switchClkDiv(switchClkDiv), .refClkDiv(refClkDiv), .pllCtl(pllCtl));
  nscr_cfg_requester req (.core_clk(core_clk), .cfgReq(cfgReq));

  // xorshift source
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    nTests++;
    if (g !== e) begin
      badCount++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // writable bits of each register number
  function automatic logic [31:0] wmask(input logic [7:0] r);
    case (r)
      8'h04: return MASK_CFG;
      8'h05: return MASK_NODE;
      8'h06: return MASK_PLL;
      8'h07, 8'h08: return MASK_DIV;
      8'h0C, 8'h0D: return 32'hFFFF_FFFF;
      default: return 32'h0000_0000;
    endcase
  endfunction : wmask

  // note the expected answer and levels, then issue the request
  task automatic acc(input logic w, input logic [7:0] r, input logic [31:0] d);
    nscr_exp_t e;
    logic lk;
    lk = (mdl[4][31] && r inside {[8'h05:8'h08], 8'h0C, 8'h0D}) || (mdl[4][8] && r == 8'h06);
    e = '0;
    e.isRd = !w;
    e.refd = w ? (lk || wmask(r) == 32'h0000_0000) : !(r inside {[0:1], [4:10], 12, 13});
    e.rd = mdl[r[3:0]];
    if (w && !e.refd) mdl[r[3:0]] = d & wmask(r);
    e.pls[2] = w && !e.refd && r == 8'h06;
    e.pls[1] = e.pls[2] && !d[31];
    e.pls[0] = e.pls[2] && !d[30];
    e.cfg = mdl[4];
    e.node = mdl[5];
    e.pll = mdl[6];
    e.d7 = mdl[7];
    e.d8 = mdl[8];
    expQ.push_back(e);
    req.issue(w, r, d);
  endtask : acc

  // one lookup; expected direction from the highest differing bit
  task automatic route(input logic [15:0] dst);
    logic [15:0] x;
    logic [63:0] dirs;
    logic [4:0] e;
    x = dst ^ mdl[5][15:0];
    dirs = {mdl[13], mdl[12]};
    e = 5'h10;
    for (int k = 0; k < 16; k++) if (x[k]) e = {1'b0, dirs[4*k +: 4]};
    routeQ.push_back(e);
    @(negedge core_clk);
    routeReqValid <= 1'b1;
    routeDest <= dst;
  endtask : route

  task automatic testDone();
    if (expQ.size() != 0 || routeQ.size() != 0) begin
      badCount++;
      $display("wrong value pending results expected 0 seen %0d", expQ.size() + routeQ.size());
    end
    $display("comparisons %0d mismatches %0d", nTests, badCount);
    if (badCount == 0 && nTests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : testDone

  // answer watcher: oldest note against each answer
  always @(negedge core_clk) begin
    if (cfgRsp.valid === 1'b1) begin
      if (expQ.size() == 0) chk("unexpected answer", 0, 1);
      else begin
        we = expQ.pop_front();
        chk("refused", 32'(we.refd), 32'(cfgRsp.refused));
        if (we.isRd) chk("read data", we.rd, cfgRsp.rdata);
        chk("pll pulses", 32'(we.pls), 32'({pllCtl.update, pllCtl.tileReset, pllCtl.waitLock}));
        chk("header mode", 32'(we.cfg[0]), 32'(hdrOneByte));
        chk("node id", 32'(we.node[15:0]), 32'(nodeId));
        chk("switch ratio", 32'(we.d7[15:0]), 32'(switchClkDiv));
        chk("ref ratio", 32'(we.d8[15:0]), 32'(refClkDiv));
        chk("pll fields", 32'({we.pll[29:23], we.pll[20:8], we.pll[6:0]}), 32'({pllCtl.bypass,
          pllCtl.jtagBoot, 2'b00, pllCtl.outDiv, pllCtl.fbMul, pllCtl.inDiv}));
      end
    end
    if (routeOut.valid === 1'b1) begin
      if (routeQ.size() == 0) chk("unexpected route", 0, 1);
      else chk("route", 32'(routeQ.pop_front()), 32'({routeOut.isLocal, routeOut.dir}));
    end
  end

  // hang guard
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      badCount++;
      $display("wrong value run length expected under 20000 seen 20000");
      testDone();
    end
  end

  // main sequence
  initial begin
    jtagId = rnd();
    {otp, metal} = rnd();
    t = rnd();
    bootPins = t[7:0];
    foreach (mdl[i]) mdl[i] = 32'h0000_0000;
    mdl[0] = {8'h00, bootPins, 16'h0000};
    mdl[1] = 32'h0008_0202;
    mdl[8] = 32'h0000_0003;
    mdl[9] = jtagId;
    mdl[10] = {otp, metal};
    repeat (10) @(negedge core_clk);
    resetn = 1'b1;
    repeat (4) @(negedge core_clk);
    for (int r = 0; r < 16; r++) acc(1'b0, 8'(r), 32'h0000_0000);
    req.idle();
    $display("test reset values done");
    acc(1'b1, 8'h04, 32'h0000_0101);
    acc(1'b1, 8'h06, rnd());
    acc(1'b1, 8'h07, rnd());
    acc(1'b1, 8'h04, 32'hFFFF_FFFF);
    acc(1'b1, 8'h05, rnd());
    acc(1'b1, 8'h0D, rnd());
    acc(1'b1, 8'h04, 32'h0000_0000);
    acc(1'b1, 8'h05, 32'hABCD_1234);
    acc(1'b0, 8'h05, 32'h0000_0000);
    acc(1'b1, 8'h00, rnd());
    req.idle();
    $display("test lock bits done");
    for (int i = 0; i < 4; i++) acc(1'b1, 8'h06, {2'(i), 30'(rnd())});
    acc(1'b0, 8'h06, 32'h0000_0000);
    req.idle();
    $display("test pll controls done");
    repeat (400) begin
      t = rnd();
      acc(t[4], 8'(t[3:0]), rnd());
    end
    req.idle();
    $display("test random traffic done");
    acc(1'b1, 8'h04, 32'h0000_0000);
    acc(1'b1, 8'h05, rnd());
    acc(1'b1, 8'h0C, rnd());
    acc(1'b1, 8'h0D, rnd());
    req.idle();
    repeat (2) @(negedge core_clk);
    route(mdl[5][15:0]);
    for (int k = 0; k < 16; k++) begin
      t = rnd();
      route(mdl[5][15:0] ^ (16'h0001 << k) ^ (t[15:0] & ((16'h0001 << k) - 16'h0001)));
    end
    @(negedge core_clk);
    routeReqValid <= 1'b0;
    routeDest <= ~routeDest;
    repeat (3) @(negedge core_clk);
    $display("test routing done");
    testDone();
  end
endmodule : node_switch_config_regs_test
`default_nettype wire
